// ==== hw/ssp_pins_cfg.svh ====
// timing and pin-index constants for the serial port pin block
`ifndef SSP_PINS_CFG_SVH
`define SSP_PINS_CFG_SVH
`define PIN_COUNT        6
`define PIN_RX_DATA      0
`define PIN_RX_FS        1
`define PIN_RX_CLK       2
`define PIN_TX_DATA      3
`define PIN_TX_FS        4
`define PIN_TX_CLK       5
`define SYS_CLK_HZ       10000000
`define DEF_CLK_DIV      4
`define DEF_WORD_BITS    8
`define SEL_RESET        6'h00
`define DIR_RESET        6'h00
`endif

// ==== hw/ssp_pins_pkg.sv ====
// types for the serial port pin block
package ssp_pins_pkg;
  typedef logic [5:0] pin_vec_t;
  typedef enum logic [1:0] {
    FR_IDLE  = 2'b00,
    FR_SHIFT = 2'b01
  } frame_e;
endpackage

// ==== hw/pin_sync.sv ====
// two-flop synchroniser with edge detect on the synchronised level
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] last_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~last_ff;
  assign fall  = ~sync_ff & last_ff;
endmodule

// ==== hw/sync_serial_port.sv ====
// pin mux, clock/frame generation and shift logic of the serial port
`timescale 1ns/1ps
`include "ssp_pins_cfg.svh"

// What this block does
// (RULE_01) rx_bit_clock pin is bidirectional and clocks the receive section.
// (RULE_02) receive clock may be gated or continuous; in sync mode the transmit clock clocks both.
// (RULE_03) tx_bit_clock pin is bidirectional and clocks the transmit section.
// (RULE_04) transmit clock may be gated or continuous; in sync mode clocks both.
// (RULE_05) tx_serial_out drives bits shifted out of the transmit shift register.
// (RULE_06) tx_frame_sync acts as frame sync or flag, input or output.
// (RULE_07) in sync mode tx_frame_sync aligns both transmitter and receiver.
// (RULE_08) every pin may be a general-purpose line with its own direction.
// (RULE_09) after reset every pin is a general-purpose input; here only while rst_n is low, then gpio_dir sets each direction.
// (RULE_10) rx_serial_in data shifts into the receive shift register.
// (RULE_11) rx_frame_sync is bidirectional, frame sync or flag for receiver.
// (RULE_12) per-pin select routes pin to port or general-purpose logic.
// (RULE_13) output clock/sync pins come from generators; inputs are sampled.
module sync_serial_port #(
  parameter int DIV_BITS  = 8,
  parameter int WORD_BITS = `DEF_WORD_BITS
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [5:0]           pin_in,
  output logic      [5:0]           pin_out,
  output logic      [5:0]           pin_oe,
  input  wire logic [5:0]           port_sel,
  input  wire logic [5:0]           gpio_dir,
  input  wire logic [5:0]           gpio_out,
  output logic      [5:0]           gpio_in,
  input  wire logic                 sync_mode,
  input  wire logic                 clk_master,
  input  wire logic                 fs_master,
  input  wire logic                 clk_gated,
  input  wire logic                 fs_flag_mode,
  input  wire logic                 tx_flag,
  input  wire logic                 rx_flag,
  input  wire logic [DIV_BITS-1:0]  clk_div,
  input  wire logic                 tx_enable,
  input  wire logic [WORD_BITS-1:0] tx_word,
  output logic                      tx_word_ready,
  output logic      [WORD_BITS-1:0] rx_word,
  output logic                      rx_word_valid,
  output logic                      rx_flag_in,
  output logic                      tx_flag_in
);
  localparam int CW = $clog2(WORD_BITS + 1);

  logic [5:0]           lvl;
  logic [5:0]           rise;
  logic [5:0]           fall;
  logic [5:0]           sel_ff;
  logic [DIV_BITS-1:0]  div_ff;
  logic                 gen_clk_ff;
  logic                 gen_fs_ff;
  logic [CW-1:0]        gen_cnt_ff;
  logic                 gen_run;
  logic                 gen_tick;
  logic [WORD_BITS-1:0] tx_sh_ff;
  logic [CW-1:0]        tx_cnt_ff;
  logic                 tx_bit_ff;
  logic [WORD_BITS-1:0] rx_sh_ff;
  logic [CW-1:0]        rx_cnt_ff;
  logic [WORD_BITS-1:0] rx_word_ff;
  logic                 rx_valid_ff;
  logic                 tx_ce;
  logic                 rx_ce;
  logic                 tx_fs;
  logic                 rx_fs;
  logic                 rx_dat;
  ssp_pins_pkg::frame_e tx_st_ff;

  pin_sync #(.W(`PIN_COUNT)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .level    (lvl),
    .rise     (rise),
    .fall     (fall)
  );

  // (RULE_12) per-pin function select, reset to gpio
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_ff <= `SEL_RESET;
    end else begin
      sel_ff <= port_sel;
    end
  end

  // gen clock divider: one enable pulse per half bit period
  // (RULE_02) (RULE_04) gated clock runs while a word is wanted or still shifting
  assign gen_run  = !clk_gated || tx_enable || tx_st_ff == ssp_pins_pkg::FR_SHIFT;
  assign gen_tick = gen_run && (div_ff == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
    end else if (!gen_run || div_ff == '0) begin
      div_ff <= clk_div;
    end else begin
      div_ff <= div_ff - 1'b1;
    end
  end

  // (RULE_13) internal bit clock and frame sync generators
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_clk_ff <= 1'b0;
      gen_fs_ff  <= 1'b0;
      gen_cnt_ff <= '0;
    end else if (!gen_run) begin
      gen_clk_ff <= 1'b0;
      gen_fs_ff  <= 1'b0;
      gen_cnt_ff <= '0;
    end else if (gen_tick) begin
      gen_clk_ff <= ~gen_clk_ff;
      if (gen_clk_ff) begin
        gen_fs_ff  <= (gen_cnt_ff == '0);
        gen_cnt_ff <= (gen_cnt_ff == CW'(WORD_BITS - 1)) ? '0 : gen_cnt_ff + 1'b1;
      end
    end
  end

  // (RULE_02) (RULE_04) sync mode shares tx clock; either may be gated
  // (RULE_01) (RULE_03) bit clock edges from pin or generator
  assign tx_ce = clk_master ? (gen_tick && gen_clk_ff) : rise[`PIN_TX_CLK];
  assign rx_ce = sync_mode ? tx_ce
               : (clk_master ? (gen_tick && gen_clk_ff) : rise[`PIN_RX_CLK]);

  // (RULE_06) (RULE_07) frame sync from generator or pin, shared in sync mode
  assign tx_fs  = fs_master ? gen_fs_ff : lvl[`PIN_TX_FS];
  assign rx_fs  = sync_mode ? tx_fs : (fs_master ? gen_fs_ff : lvl[`PIN_RX_FS]);
  assign rx_dat = lvl[`PIN_RX_DATA];

  // (RULE_05) transmit shift register, msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_ff  <= ssp_pins_pkg::FR_IDLE;
      tx_sh_ff  <= '0;
      tx_cnt_ff <= '0;
      tx_bit_ff <= 1'b0;
    end else if (tx_ce) begin
      if (!fs_flag_mode && tx_fs && tx_enable) begin
        tx_st_ff  <= ssp_pins_pkg::FR_SHIFT;
        tx_bit_ff <= tx_word[WORD_BITS-1];
        tx_sh_ff  <= tx_word << 1;
        tx_cnt_ff <= CW'(WORD_BITS - 1);
      end else if (tx_cnt_ff != '0) begin
        tx_bit_ff <= tx_sh_ff[WORD_BITS-1];
        tx_sh_ff  <= tx_sh_ff << 1;
        tx_cnt_ff <= tx_cnt_ff - 1'b1;
      end else begin
        tx_st_ff <= ssp_pins_pkg::FR_IDLE;
      end
    end
  end
  assign tx_word_ready = tx_ce && !fs_flag_mode && tx_fs && tx_enable;

  // (RULE_10) receive shift register, msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_ff    <= '0;
      rx_cnt_ff   <= '0;
      rx_word_ff  <= '0;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      if (rx_ce) begin
        if (!fs_flag_mode && rx_fs) begin
          rx_sh_ff  <= {{(WORD_BITS-1){1'b0}}, rx_dat};
          rx_cnt_ff <= CW'(WORD_BITS - 1);
        end else if (rx_cnt_ff != '0) begin
          rx_sh_ff  <= {rx_sh_ff[WORD_BITS-2:0], rx_dat};
          rx_cnt_ff <= rx_cnt_ff - 1'b1;
          if (rx_cnt_ff == CW'(1)) begin
            rx_word_ff  <= {rx_sh_ff[WORD_BITS-2:0], rx_dat};
            rx_valid_ff <= 1'b1;
          end
        end
      end
    end
  end
  assign rx_word       = rx_word_ff;
  assign rx_word_valid = rx_valid_ff;

  // (RULE_11) frame sync pins as flags when in flag mode
  assign rx_flag_in = lvl[`PIN_RX_FS];
  assign tx_flag_in = lvl[`PIN_TX_FS];

  // (RULE_08) (RULE_09) pin drive: gpio per-pin direction, else port function
  always_comb begin
    gpio_in = lvl;
    for (int i = 0; i < `PIN_COUNT; i++) begin
      pin_out[i] = gpio_out[i];
      pin_oe[i]  = gpio_dir[i];
    end
    if (sel_ff[`PIN_RX_DATA]) begin
      pin_out[`PIN_RX_DATA] = 1'b0;
      pin_oe[`PIN_RX_DATA]  = 1'b0;
    end
    if (sel_ff[`PIN_TX_DATA]) begin
      pin_out[`PIN_TX_DATA] = tx_bit_ff;
      pin_oe[`PIN_TX_DATA]  = 1'b1;
    end
    if (sel_ff[`PIN_TX_CLK]) begin
      pin_out[`PIN_TX_CLK] = gen_clk_ff;
      pin_oe[`PIN_TX_CLK]  = clk_master;
    end
    if (sel_ff[`PIN_RX_CLK]) begin
      pin_out[`PIN_RX_CLK] = gen_clk_ff;
      pin_oe[`PIN_RX_CLK]  = clk_master && !sync_mode;
    end
    if (sel_ff[`PIN_TX_FS]) begin
      pin_out[`PIN_TX_FS] = fs_flag_mode ? tx_flag : gen_fs_ff;
      pin_oe[`PIN_TX_FS]  = fs_master;
    end
    if (sel_ff[`PIN_RX_FS]) begin
      pin_out[`PIN_RX_FS] = fs_flag_mode ? rx_flag : gen_fs_ff;
      pin_oe[`PIN_RX_FS]  = fs_master && !sync_mode;
    end
    // (RULE_09) gpio input until released from reset
    if (!rst_n) begin
      pin_oe = '0;
    end
  end
endmodule

// ==== test/sync_serial_port_checker.sv ====
// assertions on the serial port pin block
`timescale 1ns/1ps
module sync_serial_port_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [5:0] pin_in,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] port_sel,
  input wire logic [5:0] gpio_dir,
  input wire logic [5:0] gpio_out,
  input wire logic [5:0] gpio_in,
  input wire logic       clk_master,
  input wire logic       fs_master,
  input wire logic       fs_flag_mode,
  input wire logic       rx_word_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_GPIO_OE: assert property (
    port_sel == 6'h00 && $past(port_sel) == 6'h00 |-> pin_oe == gpio_dir)
    else $error("gpio direction not on pads");
  AST_GPIO_OUT: assert property (
    port_sel == 6'h00 && $past(port_sel) == 6'h00 && $stable(gpio_out)
    |-> (pin_out & gpio_dir) == (gpio_out & gpio_dir)) else $error("gpio value not on pads");
  AST_RESET_GPIO: assert property (
    $rose(rst_n) |-> pin_oe == gpio_dir) else $error("pins not gpio after reset");
  AST_SYNC_IN: assert property (
    $past(rst_n, 4) ##0 $stable(pin_in)[*4] |-> gpio_in == pin_in)
    else $error("pad level not seen");
  AST_RXD_IN: assert property (
    port_sel[0] && $past(port_sel[0]) |-> !pin_oe[0]) else $error("rx data driven");
  AST_TXD_OUT: assert property (
    port_sel[3] && $past(port_sel[3]) |-> pin_oe[3]) else $error("tx data not driven");
  AST_TCLK_DIR: assert property (
    port_sel[5] && $past(port_sel[5]) && $stable(clk_master) |-> pin_oe[5] == clk_master)
    else $error("tx clock direction wrong");
  AST_TFS_DIR: assert property (
    port_sel[4] && $past(port_sel[4]) && $stable(fs_master) && !fs_flag_mode
    |-> pin_oe[4] == fs_master) else $error("tx frame sync direction wrong");
  AST_WORD_PULSE: assert property (
    rx_word_valid |=> !rx_word_valid) else $error("word valid too long");
  cover property (rx_word_valid);
  cover property (pin_oe[5]);
  cover property (pin_oe == 6'h2a);
  cover property (pin_oe == 6'h38);
endmodule
bind sync_serial_port sync_serial_port_checker i_chk (.clk, .rst_n, .pin_in, .pin_oe,
  .pin_out, .port_sel, .gpio_dir, .gpio_out, .gpio_in, .clk_master, .fs_master,
  .fs_flag_mode, .rx_word_valid);

// ==== test/serial_partner.sv ====
// external serial device model on the far side of the port pins
`timescale 1ns/1ps
module serial_partner (
  output logic [5:0] ext,
  input  wire logic  tx_line
);
  logic [7:0] got;
  initial ext = 6'h00;
  // gated clock, sync with bit 7 (msb, sent first)
  task automatic frame(input int ck, input int fs, input logic [7:0] d);
    #37;
    for (int i = 7; i >= 0; i--) begin
      ext[0] = d[i];
      ext[fs] = (i == 7);
      #400 ext[ck] = 1'b1;
      #350 got = {got[6:0], tx_line};
      #50 ext[ck] = 1'b0;
    end
    // released data line shows the inverse
    ext[0] = ~d[0];
    ext[fs] = 1'b0;
  endtask
endmodule

// ==== test/sync_serial_port_tb.sv ====
// testbench for the serial port pin block
`timescale 1ns/1ps
module sync_serial_port_tb;
  logic       clk = 0, rst_n = 0, sync_mode = 0, clk_master = 0, fs_master = 0;
  logic       tx_enable = 0, rx_word_valid;
  logic       clk_gated = 0, fs_flag_mode = 0, tx_flag = 0, rx_flag = 0;
  logic       tx_word_ready, rx_flag_in, tx_flag_in;
  logic [5:0] port_sel = 0, gpio_dir = 0, gpio_out = 0, pin_out, pin_oe, gpio_in, ext, pads;
  logic [7:0] tx_word = 0, rx_word, rx_seen;
  int         fail_count = 0, cmp_count = 0, n_val = 0, cyc = 0;
  always #50 clk = ~clk;
  assign pads = (pin_oe & pin_out) | (~pin_oe & ext);
  sync_serial_port i_dut (.clk, .rst_n, .pin_in(pads), .pin_out, .pin_oe, .port_sel,
    .gpio_dir, .gpio_out, .gpio_in, .sync_mode, .clk_master, .fs_master, .clk_gated,
    .fs_flag_mode, .tx_flag, .rx_flag, .clk_div(8'h03), .tx_enable,
    .tx_word, .tx_word_ready, .rx_word, .rx_word_valid, .rx_flag_in, .tx_flag_in);
  serial_partner i_far (.ext(ext), .tx_line(pads[3]));
  always @(posedge clk) begin
    if (rx_word_valid) begin
      rx_seen <= rx_word;
      n_val = n_val + 1;
    end
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run;
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_gpio;
    @(posedge clk);
    gpio_dir <= 6'h2a;
    gpio_out <= 6'h0f;
    i_far.ext = 6'h15;
    repeat (5) @(posedge clk);
    chk("gpio oe", 8'h2a, {2'b00, pin_oe});
    chk("gpio in", 8'h1f, {2'b00, gpio_in});
    gpio_dir <= 6'h15;
    repeat (2) @(posedge clk);
    chk("gpio oe flip", 8'h15, {2'b00, pin_oe});
    $display("gpio test done");
  endtask
  task automatic test_frame(input logic sm, input int ck, input int fs,
                            input logic [7:0] rx, input logic [7:0] tx);
    @(posedge clk);
    sync_mode <= sm;
    port_sel <= 6'h3f;
    gpio_dir <= 6'h00;
    tx_word <= tx;
    tx_enable <= 1'b1;
    i_far.ext = 6'h00;
    n_val = 0;
    repeat (4) @(posedge clk);
    chk("port oe", 8'h08, {2'b00, pin_oe});
    i_far.frame(ck, fs, rx);
    repeat (6) @(posedge clk);
    chk("rx count", 8'h01, n_val[7:0]);
    chk("rx word", rx, rx_seen);
    if (sm) chk("tx bits", tx, i_far.got);
    $display("frame test done");
  endtask
  task automatic test_master;
    @(posedge clk);
    sync_mode <= 1'b0;
    clk_master <= 1'b1;
    fs_master <= 1'b1;
    repeat (4) @(posedge clk);
    chk("master oe", 8'h3e, {2'b00, pin_oe});
    $display("master test done");
  endtask
  task automatic count_edges(input int n, output int k, output int r);
    logic prev;
    prev = pads[5];
    k = 0;
    r = 0;
    repeat (n) begin
      @(posedge clk);
      if (pads[5] !== prev) k++;
      if (tx_word_ready) r++;
      prev = pads[5];
    end
  endtask
  task automatic test_gated;
    logic       ck_prev;
    logic [7:0] sh;
    int         nb, n_edge, n_rdy;
    sh = 8'h00;
    nb = 0;
    @(posedge clk);
    sync_mode <= 1'b1;
    clk_gated <= 1'b1;
    tx_enable <= 1'b0;
    tx_word <= 8'hc6;
    i_far.ext = 6'h01;
    repeat (120) @(posedge clk);
    chk("sync master oe", 8'h38, {2'b00, pin_oe});
    count_edges(40, n_edge, n_rdy);
    chk("idle clock edges", 8'h00, n_edge[7:0]);
    chk("idle word takes", 8'h00, n_rdy[7:0]);
    n_rdy = 0;
    ck_prev = pads[5];
    tx_enable <= 1'b1;
    repeat (120) begin
      @(posedge clk);
      if (tx_word_ready) begin
        tx_enable <= 1'b0;
        n_rdy++;
      end
      if (pads[5] && !ck_prev) begin
        if (nb > 0 && nb < 9) begin
          sh = {sh[6:0], pads[3]};
          nb++;
        end
        if (nb == 0 && pads[4]) nb = 1;
      end
      ck_prev = pads[5];
    end
    chk("gated tx word", 8'hc6, sh);
    chk("gated word takes", 8'h01, n_rdy[7:0]);
    chk("gated rx word", 8'hff, rx_seen);
    count_edges(40, n_edge, n_rdy);
    chk("clock stops after word", 8'h00, n_edge[7:0]);
    $display("gated test done");
  endtask
  task automatic test_flag;
    int n_edge, n_rdy;
    @(posedge clk);
    sync_mode <= 1'b0;
    clk_gated <= 1'b0;
    fs_flag_mode <= 1'b1;
    tx_flag <= 1'b1;
    rx_flag <= 1'b0;
    tx_enable <= 1'b1;
    repeat (5) @(posedge clk);
    chk("flag pads", 8'h10, {2'b00, pads & 6'h12});
    chk("flag inputs", 8'h02, {6'h00, tx_flag_in, rx_flag_in});
    tx_flag <= 1'b0;
    rx_flag <= 1'b1;
    count_edges(100, n_edge, n_rdy);
    chk("flag pads flip", 8'h02, {2'b00, pads & 6'h12});
    chk("flag inputs flip", 8'h01, {6'h00, tx_flag_in, rx_flag_in});
    chk("free clock edges", 8'h19, n_edge[7:0]);
    chk("flag mode word takes", 8'h00, n_rdy[7:0]);
    $display("flag test done");
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    chk("reset oe", 8'h00, {2'b00, pin_oe});
    rst_n <= 1'b1;
    test_gpio;
    test_frame(1'b1, 5, 4, 8'ha5, 8'h3c);
    test_frame(1'b0, 2, 1, 8'h81, 8'h00);
    test_master;
    test_gated;
    test_flag;
    complete_run;
  end
endmodule
